//--- hw/cmp_control_page.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module cmp_control_page #(
    parameter logic [15:0] SELFTEST_SEC = cmp_pkg::SELFTEST_SEC_DEFAULT
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        ce,
    // register port
    input  wire logic [3:0]                  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [31:0]                 reg_rdata,
    // command checks
    input  wire cmp_pkg::cmp_cmd_s           cmd_in,
    output cmp_pkg::cmp_verdict_s            verdict,
    // check condition handling
    input  wire cmp_pkg::cmp_cc_s            cc_in,
    input  wire logic [cmp_pkg::NUM_INIT-1:0] queued_mask,
    input  wire logic                        ca_pending,
    output cmp_pkg::cmp_action_s             action,
    output logic                             block_all
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else if (ce) begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ************************************************************
    // page fields
    // ************************************************************
    logic        dsense_q,  dsense_d;
    logic        zero_field_check_disable_q,   zero_field_check_disable_d;
    logic [3:0]  qam_q,     qam_d;
    logic [1:0]  queue_error_policy_q,    queue_error_policy_d;
    logic        ato_q,     ato_d;
    logic        app_tag_page_enable_q,   app_tag_page_enable_d;
    logic        reject_unprotected_writes_q,    reject_unprotected_writes_d;
    logic [15:0] busy_to_q, busy_to_d;
    logic        adv_q,     adv_d;
    logic        media_q,   media_d;
    logic        save_q,    save_d;
    logic [3:0]  wqam;
    logic [1:0]  wqerr;

    always_comb begin
        dsense_d  = dsense_q;
        zero_field_check_disable_d   = zero_field_check_disable_q;
        qam_d     = qam_q;
        queue_error_policy_d    = queue_error_policy_q;
        ato_d     = ato_q;
        app_tag_page_enable_d   = app_tag_page_enable_q;
        reject_unprotected_writes_d    = reject_unprotected_writes_q;
        busy_to_d = busy_to_q;
        adv_d     = adv_q;
        media_d   = media_q;
        save_d    = save_q;
        wqam      = reg_wdata[cmp_pkg::QAM_HI:cmp_pkg::QAM_LO];
        wqerr     = reg_wdata[cmp_pkg::QUEUE_ERROR_POLICY_HI:cmp_pkg::QUEUE_ERROR_POLICY_LO];
        if (reg_wr) begin
            case (reg_addr)
                cmp_pkg::ADDR_PAGE_W0: begin
                    // byte 2 sits in [15:8], byte 3 in [7:0]; fixed-zero bits are dropped
                    zero_field_check_disable_d  = reg_wdata[8 + cmp_pkg::BIT_ZERO_FIELD_CHECK_DISABLE];
                    dsense_d = reg_wdata[8 + cmp_pkg::BIT_DSENSE];
                    // reserved modifier and policy codes keep the previous values
                    if (wqam == cmp_pkg::QAM_RESTRICTED || wqam == cmp_pkg::QAM_FREE ||
                        wqam == cmp_pkg::QAM_OFF) begin
                        qam_d = wqam;
                    end
                    if (wqerr != cmp_pkg::QUEUE_ERROR_POLICY_RSVD) begin
                        queue_error_policy_d = wqerr;
                    end
                    // queue disable bit is dropped: queuing stays on
                end
                cmp_pkg::ADDR_PAGE_W1: begin
                    // byte 5 in [23:16]
                    ato_d   = reg_wdata[16 + cmp_pkg::BIT_ATO];
                    app_tag_page_enable_d = reg_wdata[16 + cmp_pkg::BIT_APP_TAG_PAGE_ENABLE];
                    reject_unprotected_writes_d  = reg_wdata[16 + cmp_pkg::BIT_REJECT_UNPROTECTED_WRITES];
                end
                cmp_pkg::ADDR_PAGE_W2: begin
                    // stored for read-back only, never consulted
                    busy_to_d = reg_wdata[31:16];
                end
                cmp_pkg::ADDR_CONFIG: begin
                    adv_d   = reg_wdata[cmp_pkg::BIT_ADV];
                    media_d = reg_wdata[cmp_pkg::BIT_MEDIA];
                    save_d  = reg_wdata[cmp_pkg::BIT_SAVE];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dsense_q  <= 1'b0;
            zero_field_check_disable_q   <= 1'b0;
            qam_q     <= cmp_pkg::QAM_RESTRICTED;
            queue_error_policy_q    <= cmp_pkg::QUEUE_ERROR_POLICY_BLOCK;
            ato_q     <= 1'b0;
            app_tag_page_enable_q   <= 1'b0;
            reject_unprotected_writes_q    <= 1'b0;
            busy_to_q <= 16'h0000;
            adv_q     <= 1'b0;
            media_q   <= 1'b0;
            save_q    <= 1'b0;
        end else if (ce) begin
            dsense_q  <= rst_n ? dsense_d : 1'b0;
            zero_field_check_disable_q   <= rst_n ? zero_field_check_disable_d : 1'b0;
            qam_q     <= rst_n ? qam_d : cmp_pkg::QAM_RESTRICTED;
            queue_error_policy_q    <= rst_n ? queue_error_policy_d : cmp_pkg::QUEUE_ERROR_POLICY_BLOCK;
            ato_q     <= rst_n ? ato_d : 1'b0;
            app_tag_page_enable_q   <= rst_n ? app_tag_page_enable_d : 1'b0;
            reject_unprotected_writes_q    <= rst_n ? reject_unprotected_writes_d : 1'b0;
            busy_to_q <= rst_n ? busy_to_d : 16'h0000;
            adv_q     <= rst_n ? adv_d : 1'b0;
            media_q   <= rst_n ? media_d : 1'b0;
            save_q    <= rst_n ? save_d : 1'b0;
        end
    end

    // ************************************************************
    // page image and read port
    // ************************************************************
    logic [7:0]  byte2, byte3, byte5;
    logic [31:0] page_w0, page_w1, page_w2, status_w, config_w;
    logic [31:0] rdata_d, rdata_q;
    logic [15:0] reject_cnt_q, reject_cnt_d;
    logic        block_all_d, block_all_q;

    always_comb begin
        // task set type, mgmt limit, log bits read as zero
        byte2 = 8'h00;
        byte2[cmp_pkg::BIT_ZERO_FIELD_CHECK_DISABLE]  = zero_field_check_disable_q;
        byte2[cmp_pkg::BIT_DSENSE] = dsense_q;
        byte3 = 8'h00;
        byte3[cmp_pkg::QAM_HI:cmp_pkg::QAM_LO]   = qam_q;
        byte3[cmp_pkg::QUEUE_ERROR_POLICY_HI:cmp_pkg::QUEUE_ERROR_POLICY_LO] = queue_error_policy_q;
        // queue disable reads 0: queuing is always on
        byte3[0] = 1'b0;
        byte5 = 8'h00;
        byte5[cmp_pkg::BIT_ATO]   = ato_q;
        byte5[cmp_pkg::BIT_APP_TAG_PAGE_ENABLE] = app_tag_page_enable_q;
        byte5[cmp_pkg::BIT_REJECT_UNPROTECTED_WRITES]  = reject_unprotected_writes_q;
        page_w0  = {save_q, 1'b0, cmp_pkg::PAGE_CODE, cmp_pkg::PAGE_LEN,
                    byte2, byte3};
        page_w1  = {8'h00, byte5, 16'h0000};
        page_w2  = {busy_to_q, SELFTEST_SEC};
        status_w = {reject_cnt_q, 13'h0000, block_all_q, queue_error_policy_q == cmp_pkg::QUEUE_ERROR_POLICY_ABORT_ALL,
                    queue_error_policy_q == cmp_pkg::QUEUE_ERROR_POLICY_ABORT_ONE};
        config_w = {29'h00000000, save_q, media_q, adv_q};
        rdata_d  = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                cmp_pkg::ADDR_PAGE_W0: rdata_d = page_w0;
                cmp_pkg::ADDR_PAGE_W1: rdata_d = page_w1;
                cmp_pkg::ADDR_PAGE_W2: rdata_d = page_w2;
                cmp_pkg::ADDR_STATUS:  rdata_d = status_w;
                cmp_pkg::ADDR_CONFIG:  rdata_d = config_w;
                default:               rdata_d = 32'h00000000;
            endcase
        end
    end

    // ************************************************************
    // per-command decision
    // ************************************************************
    cmp_pkg::cmp_verdict_s verdict_d, verdict_q;
    logic                  pi_check;

    always_comb begin
        // zero protect field with disable set skips the check
        pi_check = cmd_in.has_pi &&
                   !(zero_field_check_disable_q && cmd_in.protect == cmp_pkg::PROTECT_NONE);
        verdict_d                = '0;
        verdict_d.valid          = cmd_in.valid;
        verdict_d.initiator      = cmd_in.initiator;
        verdict_d.check_pi       = pi_check;
        verdict_d.reject         = cmd_in.is_write && !cmd_in.has_pi &&
                                   reject_unprotected_writes_q && media_q;
        verdict_d.tag_modifiable = !ato_q;
        verdict_d.tag_from_page  = app_tag_page_enable_q && ato_q && pi_check && adv_q;
        case (qam_q)
            cmp_pkg::QAM_FREE: verdict_d.reorder = cmp_pkg::CMP_REORDER_FREE;
            cmp_pkg::QAM_OFF:  verdict_d.reorder = cmp_pkg::CMP_REORDER_OFF;
            default:           verdict_d.reorder = cmp_pkg::CMP_REORDER_RESTRICTED;
        endcase
        reject_cnt_d = reject_cnt_q;
        if (verdict_d.valid && verdict_d.reject) begin
            reject_cnt_d = reject_cnt_q + 16'h0001;
        end
    end

    // ************************************************************
    // check condition handling
    // ************************************************************
    cmp_pkg::cmp_action_s        action_d, action_q;
    logic [cmp_pkg::NUM_INIT-1:0] own_bit;

    always_comb begin
        own_bit             = {{(cmp_pkg::NUM_INIT-1){1'b0}}, 1'b1} << cc_in.initiator;
        action_d            = '0;
        action_d.valid      = cc_in.valid;
        action_d.abort_id   = cc_in.initiator;
        // format of the sense data sent with this status
        action_d.sense_desc = dsense_q;
        if (cc_in.valid) begin
            case (queue_error_policy_q)
                cmp_pkg::QUEUE_ERROR_POLICY_ABORT_ALL: begin
                    action_d.abort_all  = 1'b1;
                    action_d.ua_cleared = queued_mask & ~own_bit;
                end
                cmp_pkg::QUEUE_ERROR_POLICY_ABORT_ONE: begin
                    action_d.abort_own = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // holds all tasks only while the allegiance lasts
        block_all_d = ca_pending && queue_error_policy_q == cmp_pkg::QUEUE_ERROR_POLICY_BLOCK;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q      <= 32'h00000000;
            verdict_q    <= '0;
            action_q     <= '0;
            block_all_q  <= 1'b0;
            reject_cnt_q <= 16'h0000;
        end else if (ce) begin
            rdata_q      <= rst_n ? rdata_d : 32'h00000000;
            verdict_q    <= rst_n ? verdict_d : '0;
            action_q     <= rst_n ? action_d : '0;
            block_all_q  <= rst_n ? block_all_d : 1'b0;
            reject_cnt_q <= rst_n ? reject_cnt_d : 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign verdict   = verdict_q;
    assign action    = action_q;
    assign block_all = block_all_q;

endmodule : cmp_control_page

//--- hw/cmp_pkg.sv
//
// Contract
// - sense format select at 0 gives fixed format sense data with each CHECK CONDITION.
// - sense format select at 1 gives descriptor format sense data with each CHECK CONDITION.
// - with zero-field check disable set, protection checks are skipped when the protect field is 0.
// - queue modifier 0 restricted reorder, 1h free reorder, 8 no reorder, others reserved.
// - queue error policy 00b blocks all tasks while a contingent allegiance is pending; 10b reserved.
// - queue error policy 01b aborts all tasks on CHECK CONDITION and flags other queued initiators.
// - queue error policy 11b aborts the blocked tasks of the initiator getting CHECK CONDITION.
// - tagged queuing stays enabled and the queue disable bit is ignored.
// - owner flag set keeps the application tag untouched; clear lets it change and ignores it.
// - expected tag comes from the tag page when enable, owner, check allowed and advertised.
// - tag page enable clear disables the tag page.
// - reject-unprotected-writes on protected media ends writes without protection in error.
// - the busy timeout field never affects command handling.
// - extended self-test time is reported in seconds in 16 bits, FFFFh meaning that or longer.
// - task set type, task mgmt limit, log bits, report-check, write protect, task aborted read 0.
package cmp_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0] ADDR_PAGE_W0 = 4'h0;
    localparam logic [3:0] ADDR_PAGE_W1 = 4'h4;
    localparam logic [3:0] ADDR_PAGE_W2 = 4'h8;
    localparam logic [3:0] ADDR_STATUS  = 4'hc;
    localparam logic [3:0] ADDR_CONFIG  = 4'h2;

    // ************************************************************
    // page layout
    // ************************************************************
    localparam logic [5:0] PAGE_CODE = 6'h0a;
    localparam logic [7:0] PAGE_LEN  = 8'h0a;
    localparam int BIT_ZERO_FIELD_CHECK_DISABLE  = 3;
    localparam int BIT_DSENSE = 2;
    localparam int QAM_HI     = 7;
    localparam int QAM_LO     = 4;
    localparam int QUEUE_ERROR_POLICY_HI    = 2;
    localparam int QUEUE_ERROR_POLICY_LO    = 1;
    localparam int BIT_ATO    = 7;
    localparam int BIT_APP_TAG_PAGE_ENABLE  = 5;
    localparam int BIT_REJECT_UNPROTECTED_WRITES   = 4;
    localparam int BIT_ADV    = 0;
    localparam int BIT_MEDIA  = 1;
    localparam int BIT_SAVE   = 2;

    // ************************************************************
    // codes
    // ************************************************************
    localparam logic [3:0] QAM_RESTRICTED = 4'h0;
    localparam logic [3:0] QAM_FREE       = 4'h1;
    localparam logic [3:0] QAM_OFF        = 4'h8;
    localparam logic [1:0] QUEUE_ERROR_POLICY_BLOCK     = 2'h0;
    localparam logic [1:0] QUEUE_ERROR_POLICY_ABORT_ALL = 2'h1;
    localparam logic [1:0] QUEUE_ERROR_POLICY_RSVD      = 2'h2;
    localparam logic [1:0] QUEUE_ERROR_POLICY_ABORT_ONE = 2'h3;
    localparam logic [2:0] PROTECT_NONE   = 3'h0;
    localparam logic [15:0] SELFTEST_SEC_DEFAULT = 16'h0e10;
    localparam int NUM_INIT = 8;

    typedef enum logic [1:0] {
        CMP_REORDER_RESTRICTED,
        CMP_REORDER_FREE,
        CMP_REORDER_OFF
    } cmp_reorder_e;

    typedef struct packed {
        logic       valid;
        logic [2:0] initiator;
        logic       is_write;
        logic       has_pi;
        logic [2:0] protect;
    } cmp_cmd_s;

    typedef struct packed {
        logic         valid;
        logic [2:0]   initiator;
        logic         reject;
        logic         check_pi;
        logic         tag_from_page;
        logic         tag_modifiable;
        cmp_reorder_e reorder;
    } cmp_verdict_s;

    typedef struct packed {
        logic       valid;
        logic [2:0] initiator;
    } cmp_cc_s;

    typedef struct packed {
        logic                valid;
        logic                sense_desc;
        logic                abort_all;
        logic                abort_own;
        logic [2:0]          abort_id;
        logic [NUM_INIT-1:0] ua_cleared;
    } cmp_action_s;

endpackage : cmp_pkg

//--- tb/cmp_control_page_props.sv
`timescale 1ns/1ps
// ************************************************************
// port checker
// ************************************************************
module cmp_control_page_props #(
    parameter logic [15:0] SELFTEST_SEC = cmp_pkg::SELFTEST_SEC_DEFAULT
) (
    input wire logic                         clk,
    input wire logic                         reset_n,
    input wire logic                         ce,
    input wire logic [3:0]                   reg_addr,
    input wire logic                         reg_rd,
    input wire logic [31:0]                  reg_rdata,
    input wire cmp_pkg::cmp_cmd_s            cmd_in,
    input wire cmp_pkg::cmp_verdict_s        verdict,
    input wire cmp_pkg::cmp_cc_s             cc_in,
    input wire logic [cmp_pkg::NUM_INIT-1:0] queued_mask,
    input wire logic                         ca_pending,
    input wire cmp_pkg::cmp_action_s         action,
    input wire logic                         block_all
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_cmd;
        ce && cmd_in.valid;
    endsequence
    sequence s_cc;
        ce && cc_in.valid;
    endsequence
    chk_page_shape: assert property (
        ce && reg_rd && reg_addr == cmp_pkg::ADDR_PAGE_W0 |=> reg_rdata[30:16] == 15'h0a0a
        && reg_rdata[15:12] == 4'h0 && reg_rdata[9:8] == 2'h0 && !reg_rdata[0])
        else $error("page header or fixed bits wrong");
    chk_selftest_time: assert property (
        ce && reg_rd && reg_addr == cmp_pkg::ADDR_PAGE_W2 |=> reg_rdata[15:0] == SELFTEST_SEC)
        else $error("self-test time wrong");
    chk_rdata_quiet: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    chk_verdict_echo: assert property (
        s_cmd |=> verdict.valid && verdict.initiator == $past(cmd_in.initiator))
        else $error("verdict missing or wrong initiator");
    chk_verdict_pulse: assert property (ce && !cmd_in.valid |=> !verdict.valid)
        else $error("verdict without command");
    chk_nopi_check: assert property (s_cmd ##0 !cmd_in.has_pi |=> !verdict.check_pi)
        else $error("check without protection");
    chk_pi_reject: assert property (s_cmd ##0 cmd_in.has_pi |=> !verdict.reject)
        else $error("protected write rejected");
    chk_tag_source: assert property (
        verdict.valid && !verdict.check_pi |-> !verdict.tag_from_page)
        else $error("tag from page without checking");
    chk_ua_subset: assert property (s_cc |=> action.valid
        && (action.ua_cleared & ~$past(queued_mask)) == '0
        && !action.ua_cleared[$past(cc_in.initiator)])
        else $error("unit attention set for wrong initiator");
    chk_own_abort: assert property (
        action.valid && action.abort_own |-> action.abort_id == $past(cc_in.initiator)
        && !action.abort_all)
        else $error("own abort for wrong initiator");
    chk_block_cause: assert property (block_all |-> $past(ca_pending))
        else $error("block without pending allegiance");
endmodule : cmp_control_page_props

bind cmp_control_page cmp_control_page_props #(.SELFTEST_SEC(SELFTEST_SEC)) cmp_props_inst (
    .clk(clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_in(cmd_in), .verdict(verdict), .cc_in(cc_in),
    .queued_mask(queued_mask), .ca_pending(ca_pending), .action(action),
    .block_all(block_all)
);

//--- tb/cmp_initiator_model.sv
`timescale 1ns/1ps
// ************************************************************
// initiator side: issues commands, tracks its own queue
// ************************************************************
module cmp_initiator_model (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // requests from the bench
    input  wire cmp_pkg::cmp_cmd_s       req_cmd,
    input  wire cmp_pkg::cmp_cc_s        req_cc,
    input  wire logic                    clear_ca,
    // block side
    input  wire cmp_pkg::cmp_action_s    action,
    output cmp_pkg::cmp_cmd_s            cmd_in,
    output cmp_pkg::cmp_cc_s             cc_in,
    output logic [cmp_pkg::NUM_INIT-1:0] queued_mask,
    output logic                         ca_pending
);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_in      <= '0;
            cc_in       <= '0;
            queued_mask <= '0;
            ca_pending  <= 1'b0;
        end else begin
            // idle fields toggle so a stale value is never mistaken for live data
            cmd_in <= req_cmd.valid ? req_cmd : {1'b0, ~cmd_in[7:0]};
            cc_in  <= req_cc.valid ? req_cc : {1'b0, ~cc_in[2:0]};
            if (action.valid && action.abort_all) begin
                queued_mask <= '0;
            end else if (action.valid && action.abort_own) begin
                queued_mask[action.abort_id] <= 1'b0;
            end
            if (req_cmd.valid) begin
                queued_mask[req_cmd.initiator] <= 1'b1;
            end
            if (req_cc.valid) begin
                ca_pending <= 1'b1;
            end else if (clear_ca) begin
                ca_pending <= 1'b0;
            end
        end
    end
endmodule : cmp_initiator_model

//--- tb/test_scsi_control_mode_page.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); end end
module test_scsi_control_mode_page;
    localparam logic [15:0] SELFTEST = 16'hffff;
    typedef struct packed {
        logic [31:0]           w0;
        logic [31:0]           w1;
        logic [31:0]           w2;
        cmp_pkg::cmp_cmd_s     cmd;
        logic [3:0]            flags;
        cmp_pkg::cmp_reorder_e ro;
    } cmp_row_s;
    logic                  clk = 1'b0;
    logic                  reset_n = 1'b1;
    logic [3:0]            reg_addr = 4'h0;
    logic [31:0]           reg_wdata = 32'h0;
    logic [31:0]           reg_rdata;
    logic [31:0]           d;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic                  clear_ca = 1'b0;
    logic                  ce = 1'b1;
    logic                  block_all;
    logic                  ca_pending;
    logic [7:0]            queued_mask;
    cmp_pkg::cmp_cmd_s     req_cmd = '0;
    cmp_pkg::cmp_cmd_s     cmd_in;
    cmp_pkg::cmp_cc_s      req_cc = '0;
    cmp_pkg::cmp_cc_s      cc_in;
    cmp_pkg::cmp_verdict_s verdict;
    cmp_pkg::cmp_action_s  action;
    int                    n_mismatch = 0;
    int                    check_count = 0;
    cmp_row_s              rows [7];

    always #4 clk = ~clk;

    cmp_control_page #(.SELFTEST_SEC(SELFTEST)) cmp_control_page_inst (
        .clk(clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_in(cmd_in),
        .verdict(verdict), .cc_in(cc_in), .queued_mask(queued_mask), .ca_pending(ca_pending),
        .action(action), .block_all(block_all));
    cmp_initiator_model cmp_initiator_model_inst (
        .clk(clk), .reset_n(reset_n), .req_cmd(req_cmd), .req_cc(req_cc),
        .clear_ca(clear_ca), .action(action), .cmd_in(cmd_in), .cc_in(cc_in),
        .queued_mask(queued_mask), .ca_pending(ca_pending));

    // ************************************************************
    // bus and request tasks
    // ************************************************************
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // the model registers the request, the block answers one edge later
    task automatic send(input cmp_pkg::cmp_cmd_s c, input cmp_pkg::cmp_cc_s k);
        @(posedge clk);
        req_cmd <= c;
        req_cc  <= k;
        @(posedge clk);
        req_cmd <= '0;
        req_cc  <= '0;
        @(posedge clk);
        #1;
    endtask : send
    task automatic drop_ca;
        @(posedge clk);
        clear_ca <= 1'b1;
        @(posedge clk);
        clear_ca <= 1'b0;
    endtask : drop_ca
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        rows = '{
            {32'h0000_0000, 32'h0, 32'h0, 9'h150, 4'b0001, cmp_pkg::CMP_REORDER_RESTRICTED},
            {32'h0000_0810, 32'h0080_0000, 32'hffff_0000, 9'h188, 4'b0000,
             cmp_pkg::CMP_REORDER_FREE},
            {32'h0000_0881, 32'h00b0_0000, 32'h0, 9'h1fd, 4'b0100, cmp_pkg::CMP_REORDER_OFF},
            {32'h0000_0080, 32'h0010_0000, 32'h0, 9'h110, 4'b0001, cmp_pkg::CMP_REORDER_OFF},
            {32'h0000_0000, 32'h0080_0000, 32'h1234_0000, 9'h128, 4'b0100,
             cmp_pkg::CMP_REORDER_RESTRICTED},
            {32'h0000_0030, 32'h0, 32'h0, 9'h16a, 4'b0101, cmp_pkg::CMP_REORDER_RESTRICTED},
            {32'h0000_0890, 32'h0, 32'h0, 9'h1c8, 4'b0001, cmp_pkg::CMP_REORDER_RESTRICTED}};
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        rd(cmp_pkg::ADDR_PAGE_W0);
        `CHK(d[31:16], 16'h0a0a)
        rd(cmp_pkg::ADDR_PAGE_W2);
        `CHK(d[15:0], SELFTEST)
        rd(4'h6);
        `CHK(d, 32'h0)
        foreach (rows[i]) begin
            wr(cmp_pkg::ADDR_PAGE_W0, rows[i].w0);
            wr(cmp_pkg::ADDR_PAGE_W1, rows[i].w1);
            wr(cmp_pkg::ADDR_PAGE_W2, rows[i].w2);
            send(rows[i].cmd, '0);
            `CHK(verdict, {1'b1, rows[i].cmd.initiator, rows[i].flags, rows[i].ro})
        end
        // reserved policy and modifier codes must leave the old values
        wr(cmp_pkg::ADDR_PAGE_W0, 32'hffff_ff17);
        wr(cmp_pkg::ADDR_PAGE_W0, 32'h0000_0c34);
        rd(cmp_pkg::ADDR_PAGE_W0);
        `CHK(d, 32'h0a0a_0c16)
        wr(cmp_pkg::ADDR_PAGE_W1, 32'hffff_ffff);
        rd(cmp_pkg::ADDR_PAGE_W1);
        `CHK(d & 32'h48c0_0000, 32'h0080_0000)
        wr(cmp_pkg::ADDR_PAGE_W2, 32'h5555_aaaa);
        rd(cmp_pkg::ADDR_PAGE_W2);
        `CHK(d, {16'h5555, SELFTEST})
        // clock enable low: a write must not land
        @(posedge clk);
        ce <= 1'b0;
        wr(cmp_pkg::ADDR_PAGE_W2, 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        rd(cmp_pkg::ADDR_PAGE_W2);
        `CHK(d[31:16], 16'h5555)
        // protected media, advertised tag checks, savable page
        wr(cmp_pkg::ADDR_PAGE_W0, 32'h0);
        wr(cmp_pkg::ADDR_CONFIG, 32'h7);
        send(9'h110, '0);
        `CHK(verdict, {1'b1, 3'h0, 4'b1000, cmp_pkg::CMP_REORDER_RESTRICTED})
        send(9'h128, '0);
        `CHK(verdict.tag_from_page, 1'b1)
        wr(cmp_pkg::ADDR_PAGE_W1, 32'h0080_0000);
        send(9'h128, '0);
        `CHK(verdict.tag_from_page, 1'b0)
        rd(cmp_pkg::ADDR_STATUS);
        `CHK(d, 32'h0001_0000)
        rd(cmp_pkg::ADDR_PAGE_W0);
        `CHK(d[31:24], 8'h8a)
        // mid-run reset: every field and the partner queue start clean
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(cmp_pkg::ADDR_PAGE_W0);
        `CHK(d, 32'h0a0a_0000)
        rd(cmp_pkg::ADDR_CONFIG);
        `CHK(d, 32'h0)
        wr(cmp_pkg::ADDR_PAGE_W0, 32'h0000_0412);
        for (int i = 1; i < 6; i += 2) send({1'b1, 3'(i), 5'h08}, '0);
        send('0, 4'hb);
        `CHK({action.sense_desc, action.abort_all, action.abort_own, action.ua_cleared}, {3'b110, 8'h22})
        `CHK(block_all, 1'b0)
        drop_ca();
        wr(cmp_pkg::ADDR_PAGE_W0, 32'h0000_0016);
        send(9'h128, '0);
        send(9'h148, '0);
        send('0, 4'h9);
        `CHK({action.sense_desc, action.abort_all, action.abort_own, action.abort_id, action.ua_cleared}, {3'b001, 3'h1, 8'h00})
        drop_ca();
        wr(cmp_pkg::ADDR_PAGE_W0, 32'h0000_0010);
        send('0, 4'hc);
        `CHK({action.abort_all, action.abort_own}, 2'b00)
        `CHK(block_all, 1'b1)
        drop_ca();
        @(posedge clk);
        #1;
        `CHK(block_all, 1'b0)
        results();
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        results();
    end
endmodule : test_scsi_control_mode_page
